// *** sms_safety_status.sv ***
// input qualification, channel cross-check and status word of the safety module
// assumes channel pins and diagnostics are asynchronous, apb master on core_clk
//
// Operation
// - internal error sets status bit 0
// - report brake switch states in status
// - brake supply low/high warnings bits 3,4
// - brake overcurrent errors bits 7,21
// - no brake or measurement off warns
// - switch fault errors bits 9-12,23,24
// - supply presence 13,14; load errors 17,18
// - 5 v reference low warns bit 15
// - mirror release requests bits 16,25
// - torque-off output only while modulation possible
// - brake output only while brakes released
// - brake inputs ignore pulses under 1 ms
// - torque-off inputs tolerate test pulses
// - led green running, red on error
// - cross-check redundant channels on every change
// - modulation needs both driver supplies
// - brake output needs all handled axes open
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// pulse filter for one channel input
// ************************************************************
module sms_deglitch #(
	parameter int unsigned FILT = 1
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic nrst,
	// channel
	input  wire logic raw,
	output var  logic q_reg
);
	import sms_pkg::*;

	logic [CNT_W-1:0] cnt_reg;  // cycles the input has differed from q

	// a level must differ for FILT cycles in a row before it is taken;
	// any return to the old level restarts the count
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
			q_reg   <= 1'b0;
		end else if (raw == q_reg) begin
			cnt_reg <= '0;
		end else if (cnt_reg >= CNT_W'(FILT - 1)) begin
			q_reg   <= raw;
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule

// ************************************************************
// top
// ************************************************************
module sms_safety_status #(
	parameter int unsigned TO_FILT  = sms_pkg::TO_FILT_CYC,   // torque-off filter cycles
	parameter int unsigned BRK_FILT = sms_pkg::BRK_FILT_CYC,  // brake channel filter cycles
	parameter int unsigned DISC     = sms_pkg::DISC_CYC       // allowed mismatch cycles
) (
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     nrst,
	// apb slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output var  logic [31:0]              prdata,
	output var  logic                     pready,
	output var  logic                     pslverr,
	// channel pins
	input  wire logic [1:0]               torque_off_channel,
	input  wire logic [1:0]               brake_control_channel,
	// diagnostics
	input  wire sms_pkg::sms_diag_s       diag_in,
	// switch commands and status pins
	output var  sms_pkg::sms_switch_s     switch_out,
	output var  logic                     torque_off_status_output,
	output var  logic                     brake_status_output,
	output var  logic                     led_green,
	output var  logic                     led_red,
	output var  logic                     irq
);
	import sms_pkg::*;

	// ************************************************************
	// synchronisers
	// ************************************************************
	localparam int unsigned SYNC_W = $bits(sms_diag_s) + 4;

	logic [SYNC_W-1:0]   sync1_reg;     // first stage, read only by stage two
	logic [SYNC_W-1:0]   sync2_reg;     // stable copy
	sms_diag_s           diag;          // synchronised diagnostics
	logic [1:0]          to_raw;        // synchronised torque-off channels
	logic [1:0]          brk_raw;       // synchronised brake channels

	// every channel and diagnostic pin is asynchronous to core_clk, so all pass two flops
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {diag_in, torque_off_channel, brake_control_channel};
			sync2_reg <= sync1_reg;
		end
	end

	assign diag    = sms_diag_s'(sync2_reg[SYNC_W-1:4]);
	assign to_raw  = sync2_reg[3:2];
	assign brk_raw = sync2_reg[1:0];

	// ************************************************************
	// channel filters
	// ************************************************************
	logic [1:0] to_f;   // qualified torque-off channels
	logic [1:0] brk_f;  // qualified brake channels

	// test pulses shorter than the tolerance never reach the logic
	for (genvar i = 0; i < 2; i++) begin : g_filt
		sms_deglitch #(.FILT(TO_FILT)) u_to (
			.core_clk (core_clk),
			.nrst     (nrst),
			.raw      (to_raw[i]),
			.q_reg    (to_f[i])
		);
		sms_deglitch #(.FILT(BRK_FILT)) u_brk (
			.core_clk (core_clk),
			.nrst     (nrst),
			.raw      (brk_raw[i]),
			.q_reg    (brk_f[i])
		);
	end

	// ************************************************************
	// channel cross-check
	// ************************************************************
	logic [CNT_W-1:0] disc_to_reg;   // cycles torque-off channels disagree
	logic [CNT_W-1:0] disc_brk_reg;  // cycles brake channels disagree
	logic             disc_err_reg;  // mismatch outlasted the window

	// a status change on one channel must be followed by its twin within
	// the window; the window covers a test pulse interval of up to 10 ms
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			disc_to_reg  <= '0;
			disc_brk_reg <= '0;
			disc_err_reg <= 1'b0;
		end else begin
			disc_to_reg  <= (to_f[0] != to_f[1]) ? disc_to_reg + 1'b1 : '0;
			disc_brk_reg <= (brk_f[0] != brk_f[1]) ? disc_brk_reg + 1'b1 : '0;
			if (disc_to_reg >= CNT_W'(DISC) || disc_brk_reg >= CNT_W'(DISC)) begin
				disc_err_reg <= 1'b1;
			end
		end
	end

	// ************************************************************
	// control registers
	// ************************************************************
	logic [CTRL_W-1:0] ctrl_reg;     // brake handling and current sense
	logic [IRQ_W-1:0]  irq_en_reg;   // interrupt enables
	logic              wr_acc;       // write taken this edge
	logic              setup;        // apb setup cycle

	assign setup  = psel && !penable;
	assign wr_acc = psel && penable && pready && pwrite;

	// software steers brake handling and measurement here
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg   <= CTRL_RST;
			irq_en_reg <= '0;
		end else if (wr_acc) begin
			if (paddr == ADDR_CTRL) begin
				ctrl_reg <= pwdata[CTRL_W-1:0];
			end
			if (paddr == ADDR_IRQ_EN) begin
				irq_en_reg <= pwdata[IRQ_W-1:0];
			end
		end
	end

	// ************************************************************
	// error latch
	// ************************************************************
	logic err_reg;   // module error, held until reset
	logic err_cond;  // any error source now

	// overcurrent counts only while the measurement is on
	assign err_cond = disc_err_reg
		| (ctrl_reg[C_CUR_SENSE] & (diag.cur_high_a | diag.cur_high_b))
		| diag.hs_a_open | diag.hs_a_short | diag.ls_open | diag.ls_short
		| diag.hs_b_open | diag.hs_b_short | diag.load_upper_err | diag.load_lower_err;

	// a safety error is never self-healing; only a reset clears it
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			err_reg <= 1'b0;
		end else if (err_cond) begin
			err_reg <= 1'b1;
		end
	end

	// ************************************************************
	// brake switch commands and module outputs
	// ************************************************************
	logic hs_a_next;   // high-side a command
	logic hs_b_next;   // high-side b command
	logic ls_next;     // low-side command
	logic mod_next;    // modulation possible
	logic rel_a_next;  // brake a open
	logic rel_b_next;  // brake b open
	logic brk_next;    // every handled axis open

	// both channels feed the high sides, the low side follows either high side
	assign hs_a_next  = brk_f[0] & brk_f[1] & diag.release_req_a & ctrl_reg[C_EN_A] & ~err_reg;
	assign hs_b_next  = brk_f[0] & brk_f[1] & diag.release_req_b & ctrl_reg[C_EN_B] & ~err_reg;
	assign ls_next    = hs_a_next | hs_b_next;
	assign rel_a_next = hs_a_next & ls_next;
	assign rel_b_next = hs_b_next & ls_next;
	// both channels and both driver supplies are needed to modulate
	assign mod_next   = to_f[0] & to_f[1] & diag.upper_driver_supply
		& diag.lower_driver_supply & ~err_reg;
	// no handled axis means no release to report
	assign brk_next   = (ctrl_reg[C_EN_A] | ctrl_reg[C_EN_B])
		& (~ctrl_reg[C_EN_A] | rel_a_next) & (~ctrl_reg[C_EN_B] | rel_b_next);

	// all pins come straight from flops
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			switch_out               <= '0;
			torque_off_status_output <= 1'b0;
			brake_status_output      <= 1'b0;
			led_green                <= 1'b0;
			led_red                  <= 1'b0;
		end else begin
			switch_out.hs_a_on       <= hs_a_next;
			switch_out.hs_b_on       <= hs_b_next;
			switch_out.ls_on         <= ls_next;
			torque_off_status_output <= mod_next;
			brake_status_output      <= brk_next;
			led_green                <= ~err_reg;
			led_red                  <= err_reg;
		end
	end

	// ************************************************************
	// status word
	// ************************************************************
	logic [STAT_W-1:0] status_reg;   // safety_status_word
	logic [STAT_W-1:0] status_next;

	always_comb begin
		status_next               = '0;
		status_next[B_ERR]        = err_reg;
		status_next[B_MOD_REL]    = mod_next;
		status_next[B_REL_A]      = rel_a_next;
		status_next[B_REL_B]      = rel_b_next;
		status_next[B_HS_A_ON]    = hs_a_next;
		status_next[B_HS_B_ON]    = hs_b_next;
		status_next[B_LS_ON]      = ls_next;
		status_next[B_VOLT_LOW]   = diag.brake_volt_low;
		status_next[B_VOLT_HIGH]  = diag.brake_volt_high;
		status_next[B_CUR_HI_A]   = ctrl_reg[C_CUR_SENSE] & diag.cur_high_a;
		status_next[B_CUR_HI_B]   = ctrl_reg[C_CUR_SENSE] & diag.cur_high_b;
		status_next[B_NOCUR_A]    = ~ctrl_reg[C_CUR_SENSE] | diag.cur_none_a;
		status_next[B_NOCUR_B]    = ~ctrl_reg[C_CUR_SENSE] | diag.cur_none_b;
		status_next[B_HS_A_OPEN]  = diag.hs_a_open;
		status_next[B_HS_A_SHORT] = diag.hs_a_short;
		status_next[B_LS_OPEN]    = diag.ls_open;
		status_next[B_LS_SHORT]   = diag.ls_short;
		status_next[B_HS_B_OPEN]  = diag.hs_b_open;
		status_next[B_HS_B_SHORT] = diag.hs_b_short;
		status_next[B_UPPER_ON]   = diag.upper_driver_supply;
		status_next[B_LOWER_ON]   = diag.lower_driver_supply;
		status_next[B_LOAD_UPPER] = diag.load_upper_err;
		status_next[B_LOAD_LOWER] = diag.load_lower_err;
		status_next[B_REF_LOW]    = diag.ref5_low;
		status_next[B_REQ_A]      = diag.release_req_a;
		status_next[B_REQ_B]      = diag.release_req_b;
	end

	// registered so the word lines up with the output pins
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	// ************************************************************
	// interrupts
	// ************************************************************
	logic [IRQ_W-1:0] irq_stat_reg;   // sticky events
	logic [IRQ_W-1:0] irq_set;        // events this cycle
	logic [IRQ_W-1:0] irq_clr;        // clear strobes this cycle
	logic [4:0]       warn_new;       // warning bits of the coming word
	logic [4:0]       warn_old;       // warning bits of the word now held

	assign warn_new = {status_next[B_VOLT_LOW], status_next[B_VOLT_HIGH], status_next[B_NOCUR_A],
		status_next[B_NOCUR_B], status_next[B_REF_LOW]};
	assign warn_old = {status_reg[B_VOLT_LOW], status_reg[B_VOLT_HIGH], status_reg[B_NOCUR_A],
		status_reg[B_NOCUR_B], status_reg[B_REF_LOW]};
	assign irq_set[I_ERR]     = err_cond & ~err_reg;
	assign irq_set[I_TO_CHG]  = mod_next != torque_off_status_output;
	assign irq_set[I_BRK_CHG] = brk_next != brake_status_output;
	// each warning bit that rises counts, even while another one is already up
	assign irq_set[I_WARN]    = |(warn_new & ~warn_old);
	assign irq_clr = (wr_acc && paddr == ADDR_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;

	// a new event in the clearing cycle survives the clear
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
		end
	end

	// level output, registered on the same edge as the sticky bits
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |((irq_stat_reg & ~irq_clr | irq_set) & irq_en_reg);
		end
	end

	// ************************************************************
	// apb read path
	// ************************************************************
	// answer is prepared in the setup cycle, so the access phase ends
	// after one cycle; unmapped addresses answer with pslverr
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			prdata  <= RD_ZERO;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (setup) begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= RD_ZERO;
			case (paddr)
				ADDR_STATUS: begin
					prdata <= {{(32-STAT_W){1'b0}}, status_reg};
				end
				ADDR_IRQ_STAT: begin
					prdata <= {{(32-IRQ_W){1'b0}}, irq_stat_reg};
				end
				ADDR_IRQ_CLR: begin
					prdata <= RD_ZERO;
				end
				ADDR_IRQ_EN: begin
					prdata <= {{(32-IRQ_W){1'b0}}, irq_en_reg};
				end
				ADDR_CTRL: begin
					prdata <= {{(32-CTRL_W){1'b0}}, ctrl_reg};
				end
				default: begin
					pslverr <= 1'b1;
				end
			endcase
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// *** sms_pkg.sv ***
// shared constants and types of the safety module status and input block
// assumes a 125 MHz core clock and an apb master with 32-bit data
package sms_pkg;

	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int unsigned CLK_HZ        = 125_000_000;         // core_clk rate
	localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;  // cycles in one microsecond
	localparam int unsigned TO_FILT_US    = 1800;                // torque-off pulse tolerance, 1.8 ms
	localparam int unsigned BRK_FILT_US   = 1000;                // brake channel pulse filter, 1 ms
	localparam int unsigned DISC_US       = 10000;               // allowed channel mismatch, 10 ms
	localparam int unsigned TO_FILT_CYC   = TO_FILT_US * CYC_PER_US;
	localparam int unsigned BRK_FILT_CYC  = BRK_FILT_US * CYC_PER_US;
	localparam int unsigned DISC_CYC      = DISC_US * CYC_PER_US;
	localparam int unsigned CNT_W         = 24;                  // width of every timing counter

	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam int unsigned ADDR_W        = 12;
	localparam logic [11:0] ADDR_STATUS   = 12'h000;  // safety_status_word, read only
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h004;  // sticky event bits, read only
	localparam logic [11:0] ADDR_IRQ_CLR  = 12'h008;  // write one to clear, write only
	localparam logic [11:0] ADDR_IRQ_EN   = 12'h00C;  // interrupt enables
	localparam logic [11:0] ADDR_CTRL     = 12'h010;  // brake handling and current sense

	// ************************************************************
	// safety_status_word bit positions
	// ************************************************************
	localparam int unsigned STAT_W        = 26;
	localparam int unsigned B_ERR         = 0;
	localparam int unsigned B_MOD_REL     = 1;
	localparam int unsigned B_REL_A       = 2;
	localparam int unsigned B_VOLT_LOW    = 3;
	localparam int unsigned B_VOLT_HIGH   = 4;
	localparam int unsigned B_HS_A_ON     = 5;
	localparam int unsigned B_LS_ON       = 6;
	localparam int unsigned B_CUR_HI_A    = 7;
	localparam int unsigned B_NOCUR_A     = 8;
	localparam int unsigned B_HS_A_OPEN   = 9;
	localparam int unsigned B_HS_A_SHORT  = 10;
	localparam int unsigned B_LS_OPEN     = 11;
	localparam int unsigned B_LS_SHORT    = 12;
	localparam int unsigned B_UPPER_ON    = 13;
	localparam int unsigned B_LOWER_ON    = 14;
	localparam int unsigned B_REF_LOW     = 15;
	localparam int unsigned B_REQ_A       = 16;
	localparam int unsigned B_LOAD_UPPER  = 17;
	localparam int unsigned B_LOAD_LOWER  = 18;
	localparam int unsigned B_REL_B       = 19;
	localparam int unsigned B_HS_B_ON     = 20;
	localparam int unsigned B_CUR_HI_B    = 21;
	localparam int unsigned B_NOCUR_B     = 22;
	localparam int unsigned B_HS_B_OPEN   = 23;
	localparam int unsigned B_HS_B_SHORT  = 24;
	localparam int unsigned B_REQ_B       = 25;

	// ************************************************************
	// control and interrupt fields
	// ************************************************************
	localparam int unsigned C_EN_A        = 0;            // brake handling axis a
	localparam int unsigned C_EN_B        = 1;            // brake handling axis b
	localparam int unsigned C_CUR_SENSE   = 2;            // brake current measurement on
	localparam int unsigned CTRL_W        = 3;
	localparam logic [2:0]  CTRL_RST      = 3'h4;         // measurement on, no axis handled
	localparam int unsigned IRQ_W         = 4;
	localparam int unsigned I_ERR         = 0;            // module entered error
	localparam int unsigned I_TO_CHG      = 1;            // torque-off status changed
	localparam int unsigned I_BRK_CHG     = 2;            // brake status changed
	localparam int unsigned I_WARN        = 3;            // a warning bit rose
	localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

	// diagnostic levels from the analogue front end and drive control
	typedef struct packed {
		logic upper_driver_supply;   // upper driver supply present
		logic lower_driver_supply;   // lower driver supply present
		logic brake_volt_low;        // brake supply too low
		logic brake_volt_high;       // brake supply too high
		logic cur_high_a;            // brake a current above limit
		logic cur_high_b;            // brake b current above limit
		logic cur_none_a;            // brake a draws no current
		logic cur_none_b;            // brake b draws no current
		logic hs_a_open;             // high-side a high resistance
		logic hs_a_short;            // high-side a short
		logic ls_open;               // low-side high resistance
		logic ls_short;              // low-side short
		logic hs_b_open;             // high-side b high resistance
		logic hs_b_short;            // high-side b short
		logic ref5_low;              // 5 v reference too low
		logic load_upper_err;        // base load resistor, upper supply
		logic load_lower_err;        // base load resistor, lower supply
		logic release_req_a;         // drive control asks brake a open
		logic release_req_b;         // drive control asks brake b open
	} sms_diag_s;

	// switch commands towards the brake output stage
	typedef struct packed {
		logic hs_a_on;
		logic hs_b_on;
		logic ls_on;
	} sms_switch_s;

endpackage

// *** sms_safety_status_sva.sv ***
// assertions on the status block's ports
// assumes the bind hands on the block's filter lengths
`timescale 1ns/1ns
`default_nettype none
module sms_safety_status_sva
	import sms_pkg::*;
#(
	parameter int unsigned TO_FILT = 8,
	parameter int unsigned BRK_FILT = 6
) (
	// clock, reset and apb
	input wire logic core_clk, nrst, psel, penable, pwrite, pready,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	// pins
	input wire logic [1:0] torque_off_channel, brake_control_channel,
	input wire sms_pkg::sms_diag_s diag_in,
	input wire sms_pkg::sms_switch_s switch_out,
	input wire logic torque_off_status_output, brake_status_output, led_green, led_red
);
	// runs of missing supply or channel; saturate so a long idle never wraps
	logic [23:0] sup_lo, to_lo, brk_lo;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sup_lo <= '0;
			to_lo <= '0;
			brk_lo <= '0;
		end else begin
			sup_lo <= (diag_in.upper_driver_supply && diag_in.lower_driver_supply) ? '0 : sup_lo + 24'(sup_lo != '1);
			to_lo <= (torque_off_channel == 2'b11) ? '0 : to_lo + 24'(to_lo != '1);
			brk_lo <= (brake_control_channel == 2'b11) ? '0 : brk_lo + 24'(brk_lo != '1);
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_stat_rd;
		pready && !pwrite && paddr == ADDR_STATUS;
	endsequence
	a_apb_answer: assert property (s_setup |=> pready ##1 !pready) else $error("apb answer not one cycle");
	a_upper_zero: assert property (s_stat_rd |-> prdata[31:26] == 6'h0)
		else $error("unassigned status bits set");
	a_err_bit: assert property (s_stat_rd and $past(led_red, 2) |-> prdata[B_ERR])
		else $error("error bit missing");
	a_err_sticky: assert property (led_red |=> led_red) else $error("error state left");
	a_led_excl: assert property (!(led_green && led_red)) else $error("both leds lit");
	a_err_off: assert property (led_red |-> ##2 !torque_off_status_output && !brake_status_output)
		else $error("outputs on in error");
	a_ls_any_hs: assert property (switch_out.hs_a_on || switch_out.hs_b_on |-> ##[0:1] switch_out.ls_on)
		else $error("low side off");
	a_supply_gate: assert property (torque_off_status_output |-> sup_lo < 6)
		else $error("torque off without supplies");
	a_to_filter: assert property (torque_off_status_output |-> to_lo <= TO_FILT + 5)
		else $error("torque off channel loss ignored");
	a_brk_filter: assert property (brake_status_output |-> brk_lo <= BRK_FILT + 6)
		else $error("brake channel loss ignored");
endmodule
bind sms_safety_status sms_safety_status_sva #(.TO_FILT(TO_FILT), .BRK_FILT(BRK_FILT)) u_sva (.*);
`default_nettype wire

// *** sms_switchgear_model.sv ***
// switchgear model: channel levels with staggered test pulses
// assumes pulses shorter than the block's filters
`timescale 1ns/1ns
`default_nettype none
module sms_switchgear_model #(
	parameter int unsigned PER = 30, // pulse interval, scaled like the block's 10 ms
	parameter int unsigned PW_TO = 4,
	parameter int unsigned PW_BRK = 3
) (
	input wire logic core_clk,
	input wire logic [1:0] to_on,
	input wire logic [1:0] brk_on,
	output var logic [1:0] to_ch,
	output var logic [1:0] brk_ch
);
	int unsigned cnt = 0;
	// channel 1 pulses half an interval after channel 0, so runs never join
	always @(posedge core_clk) begin
		cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
		to_ch[0] <= to_on[0] && cnt >= PW_TO;
		to_ch[1] <= to_on[1] && !(cnt >= PER / 2 && cnt < PER / 2 + PW_TO);
		brk_ch[0] <= brk_on[0] && cnt >= PW_BRK;
		brk_ch[1] <= brk_on[1] && !(cnt >= PER / 2 && cnt < PER / 2 + PW_BRK);
	end
endmodule
`default_nettype wire

// *** sms_safety_status_test.sv ***
// bench for the status block over apb
// assumes the switchgear model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module sms_safety_status_test;
	import sms_pkg::*;
	logic core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, err, torque_off_status_output, brake_status_output, led_green, led_red, irq;
	logic [1:0] to_on = '0, brk_on = '0, torque_off_channel, brake_control_channel;
	sms_diag_s diag_in = '0;
	sms_switch_s switch_out;
	int bad_count = 0, checked = 0;
	sms_safety_status #(.TO_FILT(8), .BRK_FILT(6), .DISC(40)) DUT (.*);
	sms_switchgear_model u_gear (.core_clk, .to_on, .brk_on, .to_ch(torque_off_channel), .brk_ch(brake_control_channel));
	initial forever #4 core_clk = ~core_clk;
	task automatic report_and_stop;
		if (bad_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; values read right after an edge are those sampled at it
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 50) chk("pready", 1, 0);
	endtask
	task automatic wt(int n);
		repeat (n) @(posedge core_clk);
	endtask
	initial begin
		wt(20000);
		bad_count++;
		report_and_stop();
	end
	initial begin
		wt(8);
		nrst <= 1;
		apb(0, ADDR_STATUS, 0); chk("idle status", 0, rd);
		chk("leds", 2'b10, {led_green, led_red});
		apb(1, ADDR_IRQ_EN, 32'hF);
		diag_in.upper_driver_supply <= 1;
		diag_in.lower_driver_supply <= 1;
		to_on <= 2'b11;
		wt(100);
		apb(0, ADDR_STATUS, 0); chk("run status", 32'h0000_6002, rd);
		apb(1, ADDR_CTRL, 32'h5);
		diag_in.release_req_a <= 1;
		brk_on <= 2'b11;
		wt(100);
		for (int i = 0; i < 40; i++) begin
			@(posedge core_clk); chk("outputs hold", 2'b11, {torque_off_status_output, brake_status_output});
		end
		apb(0, ADDR_STATUS, 0); chk("brake a status", 32'h0001_6066, rd);
		apb(1, ADDR_CTRL, 32'h7);
		wt(20); chk("brake b closed", 0, brake_status_output);
		diag_in.release_req_b <= 1;
		wt(20); chk("brakes open", 1, brake_status_output);
		chk("switches on", 32'h7, switch_out);
		apb(0, ADDR_STATUS, 0); chk("brake b status", 32'h0219_6066, rd);
		diag_in.brake_volt_low <= 1;
		diag_in.brake_volt_high <= 1;
		diag_in.ref5_low <= 1;
		wt(10);
		apb(0, ADDR_STATUS, 0); chk("warn status", 32'h0219_E07E, rd);
		chk("irq on", 1, irq);
		apb(1, ADDR_IRQ_EN, 0); wt(2); chk("irq masked", 0, irq);
		apb(0, ADDR_IRQ_STAT, 0); chk("irq events", 32'hE, rd);
		apb(1, ADDR_IRQ_CLR, 32'hF);
		apb(0, ADDR_IRQ_STAT, 0); chk("irq cleared", 0, rd);
		apb(1, ADDR_IRQ_EN, 32'hF);
		apb(1, ADDR_CTRL, 32'h3);
		wt(10);
		apb(0, ADDR_STATUS, 0); chk("sense off", 32'h0259_E17E, rd);
		chk("irq warn", 1, irq);
		apb(0, 12'h020, 0); chk("unmapped", 32'h1, {rd[30:0], err});
		to_on <= 2'b01;
		wt(80);
		chk("error leds", 2'b01, {led_green, led_red});
		chk("outputs off", 0, {torque_off_status_output, brake_status_output});
		apb(0, ADDR_STATUS, 0); chk("error status", 32'h0241_E119, rd);
		chk("switches off", 0, switch_out);
		{diag_in.cur_high_a, diag_in.cur_high_b, diag_in.hs_a_open, diag_in.hs_a_short, diag_in.ls_open} <= 5'h1F;
		{diag_in.ls_short, diag_in.hs_b_open, diag_in.hs_b_short, diag_in.load_upper_err, diag_in.load_lower_err} <= 5'h1F;
		apb(1, ADDR_CTRL, 32'h7);
		wt(10);
		apb(0, ADDR_STATUS, 0); chk("fault status", 32'h03A7_FE99, rd);
		report_and_stop();
	end
endmodule
`default_nettype wire
